// *** psq_power_manager.sv ***
`include "psq_regs.svh"
`timescale 1ns/10ps
module psq_power_manager #(
  parameter int unsigned SUP_CYC = `PSQ_SUP_TIME_MS * 1000 * `PSQ_CLK_MHZ // Supervision cycles
) (
  input  wire logic                i_clk_sys, // System clock, 50 MHz
  input  wire logic                i_rstn,    // Async reset, active low
  psq_if.dev                       link,      // Link to controller side
  output      psq_pkg::psq_state_e o_mode     // Present state
);
  import psq_pkg::*;

  psq_pins_t  pin_s1_q;     // Synchroniser first stage
  psq_pins_t  pin_s2_q;     // Synchroniser second stage
  psq_pins_t  pin_s3_q;     // Delay for edge detection
  psq_state_e state_q;      // Sequencer state
  psq_state_e state_d;      // Next sequencer state
  psq_flags_t flags_q;      // Sticky flags
  psq_flags_t flag_set;     // Flag set terms this cycle
  logic [3:0] seq_cnt_q;    // Notify and boot timer
  logic [31:0] sup_cnt_q;   // Restart supervision timer
  logic       sup_arm_q;    // Supervision running
  logic [31:0] dm_cnt_q;    // Dead-man counter
  logic       rtc_rst_q;    // Output flops
  logic       periph_rst_q;
  logic       core_rst_q;
  logic       clk_stop_q;
  logic       notify_q;
  logic       supply_q;
  logic       carrier_q;
  psq_state_e mode_q;

  // States in which the core may be running
  function automatic logic is_live(input psq_state_e s);
    return (s == ST_BOOT) || (s == ST_RUN) || (s == ST_STBY) || (s == ST_SUSP);
  endfunction

  // True when the state is newly entered
  function automatic logic enters(input psq_state_e nxt, input psq_state_e cur,
                                  input psq_state_e s);
    return (nxt == s) && (cur != s);
  endfunction

  // Pin synchronisers; stage one feeds stage two only
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1_q <= `PSQ_PIN_RST;
      pin_s2_q <= `PSQ_PIN_RST;
      pin_s3_q <= `PSQ_PIN_RST;
    end else begin
      pin_s1_q <= link.pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Decoded pin and timer conditions
  logic rtc_act;   // Clock reset held
  logic sw_act;    // Reset switch held
  logic sw_rel;    // Reset switch just released
  logic wake;      // Any wake source edge
  logic inh_ok;    // Battery inhibit high
  logic lock_ok;   // Battery lock held
  logic runout;    // Battery runout seen
  logic sup_exp;   // Supervision expired
  logic dm_exp;    // Dead-man expired
  assign rtc_act = !pin_s2_q[`PSQ_P_RTC_N];
  assign sw_act  = !pin_s2_q[`PSQ_P_SW_N];
  assign sw_rel  = pin_s2_q[`PSQ_P_SW_N] && !pin_s3_q[`PSQ_P_SW_N];
  // Rising edges only, so a held switch cannot loop power-up
  assign wake    = (pin_s2_q[`PSQ_P_PWRSW] && !pin_s3_q[`PSQ_P_PWRSW]) ||
                   (pin_s2_q[`PSQ_P_CARRIER] && !pin_s3_q[`PSQ_P_CARRIER]) ||
                   (pin_s2_q[`PSQ_P_ALARM] && !pin_s3_q[`PSQ_P_ALARM]);
  assign inh_ok  = pin_s2_q[`PSQ_P_INHIBIT];
  assign lock_ok = pin_s2_q[`PSQ_P_LOCK];
  assign runout  = pin_s2_q[`PSQ_P_RUNOUT];
  assign sup_exp = sup_arm_q && (sup_cnt_q == 32'h0);
  assign dm_exp  = link.dm_en && (link.dm_interval != 32'h0) &&
                   (dm_cnt_q >= link.dm_interval);

  // Sequencer next state and flag set terms
  always_comb begin
    state_d  = state_q;
    flag_set = '0;
    if (rtc_act) begin
      state_d = ST_OFF;
      flag_set[`PSQ_F_CLKRST] = 1'b1;
    end else if (sw_act) begin
      state_d = ST_OFF;
      flag_set[`PSQ_F_SWRST] = 1'b1;
    end else if (sw_rel) begin
      state_d = ST_NOTIFY;
    end else if (is_live(state_q) && sup_exp) begin
      state_d = ST_OFF;
      flag_set[`PSQ_F_TIMEOUT] = 1'b1;
    end else if (is_live(state_q) && dm_exp) begin
      state_d = ST_OFF;
      flag_set[`PSQ_F_DEADMAN] = 1'b1;
    end else if (is_live(state_q) && runout) begin
      state_d = ST_OFF;
      flag_set[`PSQ_F_TIMEOUT] = 1'b1;
    end else if (is_live(state_q) && !lock_ok) begin
      state_d = ST_OFF;
    end else begin
      case (state_q)
        // Shut down, waiting for a wake edge
        ST_OFF: begin
          if (wake) begin
            state_d = ST_NOTIFY;
          end
        end
        // Notify held; wake edges fall through unseen
        ST_NOTIFY: begin
          if (seq_cnt_q == 4'h0) begin
            state_d = ST_CHECK;
          end
        end
        // Sample inhibit, then start or fall back
        ST_CHECK: begin
          if (!inh_ok) begin
            state_d = ST_OFF;
            flag_set[`PSQ_F_INHIBIT] = 1'b1;
          end else if (runout || !lock_ok) begin
            state_d = ST_OFF;
          end else begin
            state_d = ST_BOOT;
          end
        end
        // Cold reset sequence with peripherals released
        ST_BOOT: begin
          if (seq_cnt_q == 4'h0) begin
            state_d = ST_RUN;
          end
        end
        // Full speed; low-power only by instruction
        ST_RUN: begin
          if (link.instr_hib && !link.irq_pend) begin
            state_d = ST_HIBR;
          end else if (link.instr_susp) begin
            state_d = ST_SUSP;
          end else if (link.instr_stby) begin
            state_d = ST_STBY;
          end
        end
        // Any interrupt returns to full speed
        ST_STBY, ST_SUSP: begin
          if (link.irq_pend) begin
            state_d = ST_RUN;
          end
        end
        // Only the three wake sources or a reset switch or clock reset leave hibernate
        ST_HIBR: begin
          if (wake) begin
            state_d = ST_NOTIFY;
          end
        end
        default: begin
          state_d = ST_OFF;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Notify and boot timer
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      seq_cnt_q <= 4'h0;
    end else if (enters(state_d, state_q, ST_NOTIFY)) begin
      seq_cnt_q <= `PSQ_NOTIFY_CYC - 4'h1;
    end else if (enters(state_d, state_q, ST_BOOT)) begin
      seq_cnt_q <= `PSQ_BOOT_CYC - 4'h1;
    end else if (seq_cnt_q != 4'h0) begin
      seq_cnt_q <= seq_cnt_q - 4'h1;
    end
  end

  // Restart supervision, armed on every restart into full speed
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      sup_arm_q <= 1'b0;
      sup_cnt_q <= 32'h0;
    end else if (state_q == ST_BOOT && state_d == ST_RUN) begin
      sup_arm_q <= 1'b1;
      sup_cnt_q <= 32'(SUP_CYC - 1);
    end else if (link.sup_clr || !is_live(state_d)) begin
      sup_arm_q <= 1'b0;
    end else if (sup_arm_q && sup_cnt_q != 32'h0) begin
      sup_cnt_q <= sup_cnt_q - 32'h1;
    end
  end

  // Dead-man counter, cleared by software each interval
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      dm_cnt_q <= 32'h0;
    end else if (!link.dm_en || link.dm_clr || !is_live(state_q)) begin
      dm_cnt_q <= 32'h0;
    end else if (!dm_exp) begin
      dm_cnt_q <= dm_cnt_q + 32'h1;
    end
  end

  // Sticky flags; a set in the clear cycle wins. Hibernate sets none
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~link.flag_clr) | flag_set;
    end
  end

  // Outputs registered from next state and synchronised pin terms, so they switch with the state
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rtc_rst_q    <= 1'b1;
      periph_rst_q <= 1'b1;
      core_rst_q   <= 1'b1;
      clk_stop_q   <= 1'b0;
      notify_q     <= 1'b0;
      supply_q     <= 1'b0;
      carrier_q    <= 1'b0;
      mode_q       <= ST_OFF;
    end else begin
      rtc_rst_q    <= rtc_act;
      periph_rst_q <= rtc_act || sw_act || !is_live(state_d);
      core_rst_q   <= rtc_act || sw_act || !(is_live(state_d) && state_d != ST_BOOT);
      clk_stop_q   <= (state_d == ST_STBY) || (state_d == ST_SUSP) ||
                      (state_d == ST_HIBR);
      notify_q     <= (state_d == ST_NOTIFY);
      supply_q     <= !((state_d == ST_OFF) || (state_d == ST_HIBR) ||
                        (state_d == ST_SUSP));
      carrier_q    <= pin_s2_q[`PSQ_P_CARRIER];
      mode_q       <= state_d;
    end
  end

  // Drive the link from the output flops
  assign link.rtc_rst           = rtc_rst_q;
  assign link.periph_rst        = periph_rst_q;
  assign link.core_cold_rst     = core_rst_q;
  assign link.core_rst          = core_rst_q;
  assign link.clk_stop          = clk_stop_q;
  assign link.power_up_notify   = notify_q;
  assign link.main_supply_out   = supply_q;
  assign link.carrier_pin_level = carrier_q;
  assign link.flags             = flags_q;
  assign link.mode              = mode_q;
  assign o_mode                 = mode_q;

endmodule

// *** psq_regs.svh ***
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH

// Clock rate and timing figures
`define PSQ_CLK_MHZ      50
`define PSQ_SUP_TIME_MS  4000
`define PSQ_NOTIFY_CYC   4'h4
`define PSQ_BOOT_CYC     4'h8

// Bit positions in the pin vector
`define PSQ_P_RTC_N      0
`define PSQ_P_SW_N       1
`define PSQ_P_PWRSW      2
`define PSQ_P_CARRIER    3
`define PSQ_P_ALARM      4
`define PSQ_P_INHIBIT    5
`define PSQ_P_LOCK       6
`define PSQ_P_RUNOUT     7
`define PSQ_PIN_RST      8'h63

// Bit positions in the event flag vector
`define PSQ_F_CLKRST     0
`define PSQ_F_SWRST      1
`define PSQ_F_TIMEOUT    2
`define PSQ_F_DEADMAN    3
`define PSQ_F_INHIBIT    4

// Extra bits of the pin control register
`define PSQ_C_DM_EN      8
`define PSQ_C_IRQ        9
`define PSQ_CTL_RST      10'h063

// Bits of the command register
`define PSQ_K_STBY       0
`define PSQ_K_SUSP       1
`define PSQ_K_HIB        2
`define PSQ_K_SUPCLR     3
`define PSQ_K_DMCLR      4

// Register byte offsets
`define PSQ_A_PINS       8'h00
`define PSQ_A_CMD        8'h04
`define PSQ_A_DMIV       8'h08
`define PSQ_A_STAT       8'h0c
`define PSQ_A_FLAGS      8'h10

`endif

// *** psq_pkg.sv ***
package psq_pkg;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_OFF    = 8'h01,
    ST_NOTIFY = 8'h02,
    ST_CHECK  = 8'h04,
    ST_BOOT   = 8'h08,
    ST_RUN    = 8'h10,
    ST_STBY   = 8'h20,
    ST_SUSP   = 8'h40,
    ST_HIBR   = 8'h80
  } psq_state_e;

  typedef logic [4:0] psq_flags_t;  // Sticky event flags
  typedef logic [7:0] psq_pins_t;   // External pin levels

endpackage

// *** psq_if.sv ***
`timescale 1ns/10ps
interface psq_if;
  // Controller side to power manager
  psq_pkg::psq_pins_t  pins;              // External pin levels
  logic                irq_pend;          // Interrupt pending level
  logic                instr_stby;        // Standby instruction pulse
  logic                instr_susp;        // Suspend instruction pulse
  logic                instr_hib;         // Hibernate instruction pulse
  logic                sup_clr;           // restart_supervision_clear pulse
  logic                dm_clr;            // deadman_clear_bit pulse
  logic                dm_en;             // Dead-man supervision enable
  logic [31:0]         dm_interval;       // Dead-man interval in cycles
  psq_pkg::psq_flags_t flag_clr;          // Flag clear pulses
  // Power manager to controller side
  logic                rtc_rst;           // RTC reset line
  logic                periph_rst;        // Peripheral reset line
  logic                core_cold_rst;     // Core cold reset line
  logic                core_rst;          // Core reset line
  logic                clk_stop;          // CPU clock-stop request
  logic                power_up_notify;   // Power-on notification
  logic                main_supply_out;   // Main supply enable
  logic                carrier_pin_level; // Carrier pin level
  psq_pkg::psq_flags_t flags;             // Sticky event flags
  psq_pkg::psq_state_e mode;              // Present state

  modport dev (
    input  pins, irq_pend, instr_stby, instr_susp, instr_hib, sup_clr, dm_clr,
    input  dm_en, dm_interval, flag_clr,
    output rtc_rst, periph_rst, core_cold_rst, core_rst, clk_stop,
    output power_up_notify, main_supply_out, carrier_pin_level, flags, mode
  );
  modport ctrl (
    output pins, irq_pend, instr_stby, instr_susp, instr_hib, sup_clr, dm_clr,
    output dm_en, dm_interval, flag_clr,
    input  rtc_rst, periph_rst, core_cold_rst, core_rst, clk_stop,
    input  power_up_notify, main_supply_out, carrier_pin_level, flags, mode
  );
endinterface

// *** psq_controller.sv ***
`include "psq_regs.svh"
`timescale 1ns/10ps
module psq_controller (
  input  wire logic        i_clk_sys,   // System clock
  input  wire logic        i_rstn,      // Async reset, active low
  input  wire logic        i_hsel,      // AHB select
  input  wire logic [31:0] i_haddr,     // AHB address
  input  wire logic [1:0]  i_htrans,    // AHB transfer type
  input  wire logic        i_hwrite,    // AHB write
  input  wire logic [2:0]  i_hsize,     // AHB size, word only
  input  wire logic [31:0] i_hwdata,    // AHB write data
  input  wire logic        i_hready,    // AHB ready in
  output      logic        o_hreadyout, // AHB ready out
  output      logic        o_hresp,     // AHB response, always OKAY
  output      logic [31:0] o_hrdata,    // AHB read data
  psq_if.ctrl              link         // Link to power manager
);
  import psq_pkg::*;

  logic [9:0]  ctl_q;      // Pin levels, dead-man enable, irq pending
  logic [4:0]  cmd_q;      // One-cycle command pulses
  logic [31:0] dmiv_q;     // Dead-man interval
  psq_flags_t  fclr_q;     // One-cycle flag clear pulses
  logic        wr_q;       // Write data phase pending
  logic [7:0]  addr_q;     // Captured byte offset
  logic [31:0] rdata_q;    // Read data flop
  logic        ready_q;    // Ready out flop
  logic        accept;     // Address phase taken

  // Read decode; unmapped offsets read zero
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case (a)
      `PSQ_A_PINS:  rd_word = {22'h0, ctl_q};
      `PSQ_A_DMIV:  rd_word = dmiv_q;
      // Status: clock stop and reset lines, mode, supply, notify, carrier, flags
      `PSQ_A_STAT:  rd_word = {12'h0, link.clk_stop, link.core_cold_rst, link.periph_rst,
                               link.rtc_rst, link.mode, link.main_supply_out,
                               link.power_up_notify, link.carrier_pin_level, link.flags};
      `PSQ_A_FLAGS: rd_word = {27'h0, link.flags};
      default:      rd_word = 32'h0;
    endcase
  endfunction

  // Single word transfers only; size is not checked
  assign accept = i_hsel && i_htrans[1] && i_hready;

  // Address phase capture and read data
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q    <= 1'b0;
      addr_q  <= 8'h0;
      rdata_q <= 32'h0;
    end else begin
      wr_q <= accept && i_hwrite;
      if (accept) begin
        addr_q <= i_haddr[7:0];
      end
      if (accept && !i_hwrite) begin
        rdata_q <= rd_word(i_haddr[7:0]);
      end
    end
  end

  // Zero-wait slave: ready stays high, response stays OKAY
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= 1'b1;
    end
  end

  // Level registers written in the data phase
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_q  <= `PSQ_CTL_RST;
      dmiv_q <= 32'h0;
    end else if (wr_q && addr_q == `PSQ_A_PINS) begin
      ctl_q <= i_hwdata[9:0];
    end else if (wr_q && addr_q == `PSQ_A_DMIV) begin
      dmiv_q <= i_hwdata;
    end
  end

  // Pulses last one cycle so each write acts once
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cmd_q  <= 5'h0;
      fclr_q <= '0;
    end else begin
      cmd_q  <= (wr_q && addr_q == `PSQ_A_CMD) ? i_hwdata[4:0] : 5'h0;
      fclr_q <= (wr_q && addr_q == `PSQ_A_FLAGS) ? i_hwdata[4:0] : 5'h0;
    end
  end

  assign o_hreadyout      = ready_q;
  assign o_hresp          = 1'b0;
  assign o_hrdata         = rdata_q;
  assign link.pins        = ctl_q[7:0];
  assign link.dm_en       = ctl_q[`PSQ_C_DM_EN];
  assign link.irq_pend    = ctl_q[`PSQ_C_IRQ];
  assign link.dm_interval = dmiv_q;
  assign link.instr_stby  = cmd_q[`PSQ_K_STBY];
  assign link.instr_susp  = cmd_q[`PSQ_K_SUSP];
  assign link.instr_hib   = cmd_q[`PSQ_K_HIB];
  assign link.sup_clr     = cmd_q[`PSQ_K_SUPCLR];
  assign link.dm_clr      = cmd_q[`PSQ_K_DMCLR];
  assign link.flag_clr    = fclr_q;

endmodule

// *** psq_props.sv ***
`timescale 1ns/10ps
module psq_props
  import psq_pkg::*;
(
  input wire logic                i_clk_sys,         // System clock
  input wire logic                i_rstn,            // Async reset, active low
  input wire psq_pkg::psq_pins_t  pins,              // Pin levels from controller
  input wire logic                irq_pend,          // Interrupt pending
  input wire logic                instr_hib,         // Hibernate pulse
  input wire logic                rtc_rst,           // RTC reset line
  input wire logic                periph_rst,        // Peripheral reset
  input wire logic                core_cold_rst,     // Core cold reset
  input wire logic                core_rst,          // Core reset
  input wire logic                clk_stop,          // Clock-stop request
  input wire logic                power_up_notify,   // Power-on notify
  input wire logic                main_supply_out,   // Main supply
  input wire logic                carrier_pin_level, // Carrier level
  input wire psq_pkg::psq_flags_t flags,             // Sticky flags
  input wire psq_pkg::psq_state_e mode               // Present state
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  // Pins pass a synchroniser, hence the short windows
  property p_rtc_rst;
    !pins[0] |-> ##[1:4] (rtc_rst && periph_rst && core_cold_rst && core_rst);
  endproperty
  property p_rtc_flag;
    $fell(pins[0]) |-> ##[1:5] flags[0];
  endproperty
  property p_sw_rst;
    (!pins[1] && pins[0]) |-> ##[1:4] (periph_rst && core_cold_rst && !rtc_rst);
  endproperty
  property p_sw_flag;
    $fell(pins[1]) |-> ##[1:5] flags[1];
  endproperty
  property p_notify;
    $rose(power_up_notify) |-> power_up_notify[*4] ##1 !power_up_notify;
  endproperty
  property p_boot;
    $rose(mode == ST_BOOT) |-> (!periph_rst && core_cold_rst)[*8]
      ##1 (mode == ST_RUN && !core_cold_rst);
  endproperty
  property p_inhibit;
    (mode == ST_CHECK && !pins[5]) |=> (mode == ST_OFF && flags[4] && !main_supply_out);
  endproperty
  property p_hib_irq;
    (mode == ST_RUN && instr_hib && irq_pend) |=> !clk_stop;
  endproperty
  property p_hib_go;
    (mode == ST_RUN && instr_hib && !irq_pend) |=> (clk_stop && periph_rst && $stable(flags));
  endproperty
  property p_carrier;
    $rose(pins[3]) |-> ##[1:4] carrier_pin_level;
  endproperty
  property p_hib_cause;
    $rose(mode == ST_HIBR) |-> $past(instr_hib);
  endproperty

  a_rtc_rst:   assert property (p_rtc_rst)   else $error("clock reset outputs missing");
  a_rtc_flag:  assert property (p_rtc_flag)  else $error("clock reset flag not set");
  a_sw_rst:    assert property (p_sw_rst)    else $error("switch reset outputs wrong");
  a_sw_flag:   assert property (p_sw_flag)   else $error("switch reset flag not set");
  a_notify:    assert property (p_notify)    else $error("notify length wrong");
  a_boot:      assert property (p_boot)      else $error("boot sequence wrong");
  a_inhibit:   assert property (p_inhibit)   else $error("inhibit did not shut down");
  a_hib_irq:   assert property (p_hib_irq)   else $error("hibernate taken with irq");
  a_hib_go:    assert property (p_hib_go)    else $error("hibernate outputs wrong");
  a_carrier:   assert property (p_carrier)   else $error("carrier level not shown");
  a_hib_cause: assert property (p_hib_cause) else $error("hibernate without command");

  // Main scenarios reached
  c_run:  cover property ($rose(mode == ST_RUN));
  c_hibr: cover property ($rose(mode == ST_HIBR));
  c_inh:  cover property ($rose(flags[4]));
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  import psq_pkg::*;
  localparam logic [31:0] P = 32'h63; // Idle pins: no resets, inhibit ok, locked
  logic        i_clk_sys = 1'b0; // 50 MHz clock
  logic        i_rstn    = 1'b0; // Reset, active low
  logic        hsel      = 1'b0; // AHB select
  logic [1:0]  htrans    = 2'h0; // AHB transfer type
  logic        hwrite    = 1'b0; // AHB direction
  logic [31:0] haddr     = 32'h0; // AHB address
  logic [31:0] hwdata    = 32'h0; // AHB write data
  logic [31:0] hrdata;           // AHB read data
  logic        hready;           // Single slave, so its ready is the bus ready
  psq_state_e  mode_out;         // State port of the device end
  int          fail_count = 0;   // Mismatches
  int          checked    = 0;   // Comparisons

  psq_if lk();
  psq_power_manager #(.SUP_CYC(200)) psq_power_manager_i (
    .i_clk_sys, .i_rstn, .link(lk), .o_mode(mode_out));
  psq_controller psq_controller_i (
    .i_clk_sys, .i_rstn, .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(), .o_hrdata(hrdata), .link(lk));
  psq_props props_i (
    .i_clk_sys, .i_rstn, .pins(lk.pins), .irq_pend(lk.irq_pend), .instr_hib(lk.instr_hib),
    .rtc_rst(lk.rtc_rst), .periph_rst(lk.periph_rst), .core_cold_rst(lk.core_cold_rst),
    .core_rst(lk.core_rst), .clk_stop(lk.clk_stop), .power_up_notify(lk.power_up_notify),
    .main_supply_out(lk.main_supply_out), .carrier_pin_level(lk.carrier_pin_level),
    .flags(lk.flags), .mode(lk.mode));

  always #10 i_clk_sys = ~i_clk_sys;

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, g, e);
    end
  endtask

  // One AHB single transfer; waits on ready, no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge i_clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Bounded wait for a state; polls every edge so one-cycle states are seen
  task automatic wmode(input psq_state_e m);
    int n;
    n = 0;
    while (lk.mode !== m && n < 400) begin
      @(posedge i_clk_sys);
      n++;
    end
    chk(32'(lk.mode), 32'(m));
    chk(32'(mode_out), 32'(m));
  endtask

  // Packed outputs: rtc, periph, cold, core, stop, supply, notify
  function automatic logic [31:0] outs();
    return 32'({lk.rtc_rst, lk.periph_rst, lk.core_cold_rst, lk.core_rst,
                lk.clk_stop, lk.main_supply_out, lk.power_up_notify});
  endfunction

  task automatic t_regs();
    rd(8'h00, P);
    rd(8'h0c, 32'h00060100);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h00060100);
  endtask

  // Inhibit low, then runout, each blocks the start
  task automatic t_inhibit();
    wr(8'h00, 32'h47);
    wmode(ST_CHECK);
    chk(32'(lk.power_up_notify), 32'h0);
    wmode(ST_OFF);
    chk(outs(), 32'h38);
    rd(8'h10, 32'h10);
    wr(8'h10, 32'h10);
    rd(8'h10, 32'h0);
    wr(8'h00, P);
    wr(8'h00, P | 32'h84);
    wmode(ST_CHECK);
    wmode(ST_OFF);
    rd(8'h10, 32'h0);
    wr(8'h00, P);
  endtask

  // Switch, carrier and alarm wakes, each ended by a lock release
  task automatic t_wakes();
    for (int i = 2; i < 5; i++) begin
      wr(8'h00, P | (32'h1 << i));
      wmode(ST_RUN);
      chk(outs(), 32'h02);
      chk(32'(lk.carrier_pin_level), 32'(i == 3));
      wr(8'h04, 32'h08);
      wr(8'h00, 32'h23);
      wmode(ST_OFF);
      rd(8'h10, 32'h0);
      wr(8'h00, P);
    end
  endtask

  // Standby also stops the core clock but keeps the supply
  task automatic t_modes();
    wr(8'h00, P | 32'h4);
    wmode(ST_RUN);
    wr(8'h04, 32'h08);
    wr(8'h00, P);
    wr(8'h04, 32'h01);
    wmode(ST_STBY);
    chk(outs(), 32'h06);
    wr(8'h00, P | 32'h200);
    wmode(ST_RUN);
    wr(8'h04, 32'h04);
    repeat (3) @(posedge i_clk_sys);
    chk(32'(lk.mode), 32'(ST_RUN));
    wr(8'h00, P);
    wr(8'h04, 32'h04);
    wmode(ST_HIBR);
    chk(outs(), 32'h3c);
    wr(8'h00, P | 32'h200);
    repeat (5) @(posedge i_clk_sys);
    chk(32'(lk.mode), 32'(ST_HIBR));
    wr(8'h00, P | 32'h10);
    wmode(ST_RUN);
    wr(8'h04, 32'h08);
    wr(8'h00, P);
    wr(8'h04, 32'h02);
    wmode(ST_SUSP);
    chk(outs() & 32'h2, 32'h0);
    wr(8'h00, P | 32'h200);
    wmode(ST_RUN);
    wr(8'h00, P);
  endtask

  // Switch reset restarts with supervision armed and left to expire
  task automatic t_sup();
    wr(8'h00, 32'h61);
    wmode(ST_OFF);
    chk(outs(), 32'h38);
    rd(8'h10, 32'h02);
    wr(8'h00, P);
    wmode(ST_RUN);
    wmode(ST_OFF);
    rd(8'h10, 32'h06);
    wr(8'h10, 32'h1f);
    rd(8'h10, 32'h0);
  endtask

  task automatic t_dm();
    wr(8'h00, P | 32'h4);
    wmode(ST_RUN);
    wr(8'h04, 32'h08);
    wr(8'h08, 32'd60);
    wr(8'h00, P | 32'h100);
    repeat (4) begin
      wr(8'h04, 32'h10);
      repeat (30) @(posedge i_clk_sys);
    end
    chk(32'(lk.mode), 32'(ST_RUN));
    wmode(ST_OFF);
    rd(8'h10, 32'h08);
    wr(8'h10, 32'h1f);
  endtask

  task automatic t_rtc();
    wr(8'h00, 32'h62);
    repeat (5) @(posedge i_clk_sys);
    chk(outs(), 32'h78);
    rd(8'h10, 32'h01);
    wr(8'h00, P);
    repeat (4) @(posedge i_clk_sys);
    rd(8'h0c, 32'h00060101);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    t_regs();
    t_inhibit();
    t_wakes();
    t_modes();
    t_sup();
    t_dm();
    t_rtc();
    conclude();
  end

  // Whole run needs several hundred cycles
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fail_count++;
    conclude();
  end
endmodule
